// *** rtl/bad_batt_timer.sv ***
// Bad battery timer that ends charging after the allowed time
`timescale 1ns/1ps
`default_nettype none
module bad_batt_timer
  import charger_cfg_pkg::*;
#(
  parameter logic [BAD_CNT_W-1:0] BAD_BATT_CYCLES = BAD_CNT_W'(BAD_BATT_CYCLES_DFLT)
) (
  // Clock and control
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic ce,
  // Battery judgement and result
  input  wire logic battery_bad,
  output logic      bad_batt_stop
);
  typedef struct packed {
    logic [BAD_CNT_W-1:0] count;
    logic                 stop;
  } timer_state_t;

  timer_state_t state_ff;
  timer_state_t nxt_state;

  always_comb begin
    nxt_state = state_ff;
    if (ce) begin
      if (!battery_bad) begin
        // A good battery rearms the timer
        nxt_state.count = '0;
        nxt_state.stop  = 1'b0;
      end else if (state_ff.count >= BAD_BATT_CYCLES - 1'b1) begin
        nxt_state.stop = 1'b1;
      end else begin
        nxt_state.count = state_ff.count + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign bad_batt_stop = state_ff.stop;

  a_stop_after_time : assert property (@(posedge ref_clk) disable iff (rst)
    $rose(state_ff.stop) |-> $past(state_ff.count) >= BAD_BATT_CYCLES - 1'b1)
    else $error("bad battery stop raised before the timer ran out");

  c_stop_reached : cover property (@(posedge ref_clk) disable iff (rst)
    $rose(state_ff.stop));
endmodule : bad_batt_timer
`default_nettype wire

// *** rtl/bit_sync.sv ***
// Two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
`default_nettype none
module bit_sync #(
  parameter int unsigned W = 1
) (
  // Clock and control
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic         ce,
  // Levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_state_t;

  sync_state_t state_ff;
  sync_state_t nxt_state;

  always_comb begin
    nxt_state = state_ff;
    if (ce) begin
      // First stage feeds only the second
      nxt_state.meta   = async_in;
      nxt_state.stable = state_ff.meta;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign sync_out = state_ff.stable;
endmodule : bit_sync
`default_nettype wire

// *** rtl/charger_cfg_pkg.sv ***
// Constants shared by the charger limit configuration block
package charger_cfg_pkg;

  // Register width and locations
  localparam int unsigned REG_W          = 8;
  localparam logic [7:0]  SER_PAGE_CFG   = 8'h00;
  localparam logic [7:0]  SER_ADDR_LIMIT = 8'h90;
  localparam logic [7:0]  SER_ADDR_CHG   = 8'h91;
  localparam logic [15:0] MCU_ADDR_LIMIT = 16'hA090;
  localparam logic [15:0] MCU_ADDR_CHG   = 16'hA091;

  // Field positions
  localparam int unsigned LIM_CODE_LSB = 0;
  localparam int unsigned LIM_CODE_W   = 3;
  localparam int unsigned LIM_SRC_BIT  = 7;
  localparam int unsigned CHARGE_CURRENT_CODE_LSB  = 0;
  localparam int unsigned CHARGE_CURRENT_CODE_W    = 4;
  localparam int unsigned MAX_VOLTAGE_CODE_LSB  = 4;
  localparam int unsigned MAX_VOLTAGE_CODE_W    = 2;

  // Reset values: source select set, all codes and reserved bits zero
  localparam logic [7:0] LIMIT_REG_RST = 8'h80;
  localparam logic [7:0] CHG_REG_RST   = 8'h00;

  // Current settings in mA
  localparam logic [11:0] MA_100  = 12'h064;
  localparam logic [11:0] MA_500  = 12'h1F4;
  localparam logic [11:0] MA_1000 = 12'h3E8;
  localparam logic [11:0] MA_1500 = 12'h5DC;
  localparam logic [11:0] MA_2000 = 12'h7D0;
  localparam logic [11:0] CHG_STEP_MA = 12'h064;

  // Battery voltage limits in mV
  localparam logic [12:0] MV_4100 = 13'h1004;
  localparam logic [12:0] MV_4150 = 13'h1036;
  localparam logic [12:0] MV_4200 = 13'h1068;

  // Bad battery time: 0.5 hours, held as 500 milli-hours
  localparam longint unsigned CLK_HZ           = 64'h17D7840;
  localparam longint unsigned BAD_BATT_TIME_MH = 64'h1F4;
  localparam longint unsigned BAD_BATT_CYCLES_DFLT =
    (BAD_BATT_TIME_MH * 64'hE10 * CLK_HZ) / 64'h3E8;
  localparam int unsigned BAD_CNT_W = 36;

endpackage : charger_cfg_pkg

// *** rtl/charger_limit_config_regs.sv ***
// Charger input limit, charge current and voltage configuration registers
//
// What this block does
// - The charger is configured and observed through 8-bit registers read and written over the serial port and by its controller.
// - The current limit register sits at serial page 0 address 0x90 and at controller address 0xA090.
// - Bits 2 to 0 of the current limit register hold a read-write limit code that resets to 000b.
// - Bit 7 of the current limit register selects the limit source, read-write, resetting to 1 for the internal code.
// - With the internal source the code gives 100, 500, 1000, 1500 or 2000 mA for 000 to 100, and 101 to 111 are invalid.
// - With the pin source the limit pin gives 500 mA low or 1500 mA high, invalid unless the pin function bit is set.
// - The charging register sits at serial page 0 address 0x91 and at controller address 0xA091.
// - Bits 3 to 0 of the charging register hold a charge current code, reset 0h, in 100 mA steps.
// - Charge codes 0000 and 0001 both give 100 mA, and higher codes give the code times 100 mA up to 1500 mA.
// - Bits 5 to 4 of the charging register hold a read-write maximum voltage code that resets to 00b.
// - The voltage code gives 4.10, 4.15 or 4.20 V for 00, 01 or 10, and 11 has no setting.
// - Charging of a battery judged bad ends after a half-hour timer runs out.
// - The remaining register bits are reserved, read-write and reset to zero.
`timescale 1ns/1ps
`default_nettype none
module charger_limit_config_regs
  import charger_cfg_pkg::*;
#(
  parameter logic [BAD_CNT_W-1:0] BAD_BATT_CYCLES = BAD_CNT_W'(BAD_BATT_CYCLES_DFLT)
) (
  // Clock, reset, enable
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             ce,
  // Serial register port (page and byte address)
  input  wire logic [7:0]       ser_page,
  input  wire logic [7:0]       ser_addr,
  input  wire logic             ser_wr,
  input  wire logic             ser_rd,
  input  wire logic [REG_W-1:0] ser_wdata,
  output logic      [REG_W-1:0] ser_rdata,
  // Controller register port
  input  wire logic [15:0]      mcu_addr,
  input  wire logic             mcu_wr,
  input  wire logic             mcu_rd,
  input  wire logic [REG_W-1:0] mcu_wdata,
  output logic      [REG_W-1:0] mcu_rdata,
  // Pins and neighbouring logic
  input  wire logic             limit_select_pin,
  input  wire logic             pin_function_config,
  input  wire logic             battery_bad,
  // Settings to the analog loops
  output logic      [11:0]      input_limit_ma,
  output logic                  input_limit_invalid,
  output logic      [11:0]      charge_current_ma,
  output logic      [12:0]      max_voltage_mv,
  output logic                  max_voltage_invalid,
  output logic                  bad_batt_stop
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [REG_W-1:0] limit_reg;
    logic [REG_W-1:0] chg_reg;
    logic [REG_W-1:0] ser_rdata;
    logic [REG_W-1:0] mcu_rdata;
    logic [11:0]      limit_ma;
    logic             limit_invalid;
    logic [11:0]      charge_ma;
    logic [12:0]      vmax_mv;
    logic             vmax_invalid;
  } cfg_state_t;

  cfg_state_t state_ff;
  cfg_state_t nxt_state;

  logic [1:0] pin_sync;

  ////////////////////////////////////////////////////////////////////////////
  // Decoders

  function automatic logic ser_hit(input logic [7:0] page, input logic [7:0] addr,
                                   input logic [7:0] target);
    ser_hit = (page == SER_PAGE_CFG) && (addr == target);
  endfunction : ser_hit

  // Returns {valid, mA}
  function automatic logic [12:0] internal_limit(input logic [LIM_CODE_W-1:0] code);
    case (code)
      3'h0:    internal_limit = {1'b1, MA_100};
      3'h1:    internal_limit = {1'b1, MA_500};
      3'h2:    internal_limit = {1'b1, MA_1000};
      3'h3:    internal_limit = {1'b1, MA_1500};
      3'h4:    internal_limit = {1'b1, MA_2000};
      default: internal_limit = {1'b0, MA_100};
    endcase
  endfunction : internal_limit

  function automatic logic [12:0] pin_limit(input logic cfg, input logic pin);
    pin_limit = {cfg, (pin ? MA_1500 : MA_500)};
  endfunction : pin_limit

  // Returns {valid, mV}
  function automatic logic [13:0] vmax_decode(input logic [MAX_VOLTAGE_CODE_W-1:0] code);
    case (code)
      2'h0:    vmax_decode = {1'b1, MV_4100};
      2'h1:    vmax_decode = {1'b1, MV_4150};
      2'h2:    vmax_decode = {1'b1, MV_4200};
      default: vmax_decode = {1'b0, MV_4100};
    endcase
  endfunction : vmax_decode

  function automatic logic [11:0] charge_decode(input logic [CHARGE_CURRENT_CODE_W-1:0] code);
    if (code < 4'h2) begin
      charge_decode = CHG_STEP_MA;
    end else begin
      charge_decode = 12'(12'(code) * CHG_STEP_MA);
    end
  endfunction : charge_decode

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Limit pin comes from outside the clock domain
  bit_sync #(.W(1)) u_pin_sync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .ce       (ce),
    .async_in (limit_select_pin),
    .sync_out (pin_sync[0])
  );

  bit_sync #(.W(1)) u_bad_sync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .ce       (ce),
    .async_in (battery_bad),
    .sync_out (pin_sync[1])
  );

  bad_batt_timer #(.BAD_BATT_CYCLES(BAD_BATT_CYCLES)) u_bad_timer (
    .ref_clk       (ref_clk),
    .rst           (rst),
    .ce            (ce),
    .battery_bad   (pin_sync[1]),
    .bad_batt_stop (bad_batt_stop)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  logic [12:0] lim_sel;
  logic [13:0] vmax_sel;

  always_comb begin
    nxt_state = state_ff;
    lim_sel   = '0;
    vmax_sel  = '0;
    if (ce) begin
      // Serial writes first; a same-cycle controller write wins
      if (ser_wr && ser_hit(ser_page, ser_addr, SER_ADDR_LIMIT)) begin
        nxt_state.limit_reg = ser_wdata;
      end else if (ser_wr && ser_hit(ser_page, ser_addr, SER_ADDR_CHG)) begin
        nxt_state.chg_reg = ser_wdata;
      end
      if (mcu_wr && mcu_addr == MCU_ADDR_LIMIT) begin
        nxt_state.limit_reg = mcu_wdata;
      end else if (mcu_wr && mcu_addr == MCU_ADDR_CHG) begin
        nxt_state.chg_reg = mcu_wdata;
      end

      // Reads return whole 8-bit registers; unmapped reads give zero
      if (ser_rd) begin
        if (ser_hit(ser_page, ser_addr, SER_ADDR_LIMIT)) begin
          nxt_state.ser_rdata = state_ff.limit_reg;
        end else if (ser_hit(ser_page, ser_addr, SER_ADDR_CHG)) begin
          nxt_state.ser_rdata = state_ff.chg_reg;
        end else begin
          nxt_state.ser_rdata = '0;
        end
      end
      if (mcu_rd) begin
        if (mcu_addr == MCU_ADDR_LIMIT) begin
          nxt_state.mcu_rdata = state_ff.limit_reg;
        end else if (mcu_addr == MCU_ADDR_CHG) begin
          nxt_state.mcu_rdata = state_ff.chg_reg;
        end else begin
          nxt_state.mcu_rdata = '0;
        end
      end

      // Source select picks the internal code or the pin
      if (state_ff.limit_reg[LIM_SRC_BIT]) begin
        lim_sel = internal_limit(state_ff.limit_reg[LIM_CODE_LSB +: LIM_CODE_W]);
      end else begin
        lim_sel = pin_limit(pin_function_config, pin_sync[0]);
      end
      // Invalid codes keep the last good value so the loop never sees junk
      nxt_state.limit_invalid = !lim_sel[12];
      if (lim_sel[12]) begin
        nxt_state.limit_ma = lim_sel[11:0];
      end

      vmax_sel = vmax_decode(state_ff.chg_reg[MAX_VOLTAGE_CODE_LSB +: MAX_VOLTAGE_CODE_W]);
      nxt_state.vmax_invalid = !vmax_sel[13];
      if (vmax_sel[13]) begin
        nxt_state.vmax_mv = vmax_sel[12:0];
      end

      nxt_state.charge_ma = charge_decode(state_ff.chg_reg[CHARGE_CURRENT_CODE_LSB +: CHARGE_CURRENT_CODE_W]);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_ff.limit_reg     <= LIMIT_REG_RST;
      state_ff.chg_reg       <= CHG_REG_RST;
      state_ff.ser_rdata     <= '0;
      state_ff.mcu_rdata     <= '0;
      state_ff.limit_ma      <= MA_100;
      state_ff.limit_invalid <= 1'b0;
      state_ff.charge_ma     <= MA_100;
      state_ff.vmax_mv       <= MV_4100;
      state_ff.vmax_invalid  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign ser_rdata           = state_ff.ser_rdata;
  assign mcu_rdata           = state_ff.mcu_rdata;
  assign input_limit_ma      = state_ff.limit_ma;
  assign input_limit_invalid = state_ff.limit_invalid;
  assign charge_current_ma   = state_ff.charge_ma;
  assign max_voltage_mv      = state_ff.vmax_mv;
  assign max_voltage_invalid = state_ff.vmax_invalid;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_reset_values : assert property (@(posedge ref_clk)
    $fell(rst) |-> state_ff.limit_reg == LIMIT_REG_RST && state_ff.chg_reg == CHG_REG_RST)
    else $error("registers not at reset values after reset");

  a_ser_limit_write : assert property (@(posedge ref_clk) disable iff (rst)
    ce && ser_wr && ser_page == SER_PAGE_CFG && ser_addr == SER_ADDR_LIMIT && !mcu_wr
    |=> state_ff.limit_reg == $past(ser_wdata))
    else $error("serial write to limit register lost");

  a_mcu_chg_write : assert property (@(posedge ref_clk) disable iff (rst)
    ce && mcu_wr && mcu_addr == MCU_ADDR_CHG |=> state_ff.chg_reg == $past(mcu_wdata))
    else $error("controller write to charging register lost");

  a_ser_read_back : assert property (@(posedge ref_clk) disable iff (rst)
    ce && ser_rd && ser_page == SER_PAGE_CFG && ser_addr == SER_ADDR_CHG
    |=> ser_rdata == $past(state_ff.chg_reg))
    else $error("serial read of charging register wrong");

  a_mcu_read_back : assert property (@(posedge ref_clk) disable iff (rst)
    ce && mcu_rd && mcu_addr == MCU_ADDR_LIMIT
    |=> mcu_rdata == $past(state_ff.limit_reg))
    else $error("controller read of limit register wrong");

  a_internal_limit : assert property (@(posedge ref_clk) disable iff (rst)
    ce && state_ff.limit_reg[LIM_SRC_BIT] && state_ff.limit_reg[2:0] == 3'h2
    |=> input_limit_ma == MA_1000 && !input_limit_invalid)
    else $error("internal code 010 did not give 1000 mA");

  a_pin_limit : assert property (@(posedge ref_clk) disable iff (rst)
    ce && !state_ff.limit_reg[LIM_SRC_BIT] && pin_function_config && pin_sync[0]
    |=> input_limit_ma == MA_1500 && !input_limit_invalid)
    else $error("pin high did not give 1500 mA");

  a_limit_hold : assert property (@(posedge ref_clk) disable iff (rst)
    ce && state_ff.limit_reg[LIM_SRC_BIT] && state_ff.limit_reg[2:0] > 3'h4
    |=> input_limit_invalid && $stable(input_limit_ma))
    else $error("invalid limit code changed the applied limit");

  a_charge_floor : assert property (@(posedge ref_clk) disable iff (rst)
    ce && state_ff.chg_reg[3:0] < 4'h2 |=> charge_current_ma == MA_100)
    else $error("charge codes 0 and 1 must give 100 mA");

  a_charge_scale : assert property (@(posedge ref_clk) disable iff (rst)
    ce && state_ff.chg_reg[3:0] == 4'hF |=> charge_current_ma == MA_1500)
    else $error("charge code 1111 did not give 1500 mA");

  a_vmax_decode : assert property (@(posedge ref_clk) disable iff (rst)
    ce && state_ff.chg_reg[5:4] == 2'h1 |=> max_voltage_mv == MV_4150 && !max_voltage_invalid)
    else $error("voltage code 01 did not give 4.15 V");

  a_vmax_hold : assert property (@(posedge ref_clk) disable iff (rst)
    ce && state_ff.chg_reg[5:4] == 2'h3 |=> max_voltage_invalid && $stable(max_voltage_mv))
    else $error("voltage code 11 changed the applied voltage");

  a_freeze : assert property (@(posedge ref_clk) disable iff (rst)
    !ce |=> $stable(state_ff))
    else $error("state moved while clock enable was low");

  c_pin_source : cover property (@(posedge ref_clk) disable iff (rst)
    ce && !state_ff.limit_reg[LIM_SRC_BIT] && pin_function_config);

  c_limit_invalid : cover property (@(posedge ref_clk) disable iff (rst)
    $rose(input_limit_invalid));

  c_max_charge : cover property (@(posedge ref_clk) disable iff (rst)
    charge_current_ma == MA_1500);

endmodule : charger_limit_config_regs
`default_nettype wire

// *** tb/charger_limit_config_regs_tb.sv ***
// Self-checking bench for the charger limit configuration registers
`timescale 1ns/1ps
`default_nettype none
module charger_limit_config_regs_tb
  import charger_cfg_pkg::*;
;
  logic        ref_clk, rst, ce, ser_wr, ser_rd, mcu_wr, mcu_rd;
  logic [7:0]  ser_page, ser_addr, ser_wdata, ser_rdata, mcu_wdata, mcu_rdata, d, chg_keep;
  logic [15:0] mcu_addr, h_addr;
  logic        limit_select_pin, pin_function_config, battery_bad, bad_batt_stop;
  logic [11:0] input_limit_ma, charge_current_ma, e_lim, e_cur;
  logic [12:0] max_voltage_mv, e_mv;
  logic        input_limit_invalid, max_voltage_invalid, e_linv, e_vinv, e_stop;
  logic        h_go, h_wr, h_busy, pend_s, pend_m;
  logic [3:0]  h_dly;
  logic [7:0]  q[$];
  int          n_mismatch, n_tests, n;

  charger_limit_config_regs #(.BAD_BATT_CYCLES(36'h14)) charger_limit_config_regs_inst (
    .ref_clk(ref_clk), .rst(rst), .ce(ce),
    .ser_page(ser_page), .ser_addr(ser_addr), .ser_wr(ser_wr), .ser_rd(ser_rd),
    .ser_wdata(ser_wdata), .ser_rdata(ser_rdata),
    .mcu_addr(mcu_addr), .mcu_wr(mcu_wr), .mcu_rd(mcu_rd),
    .mcu_wdata(mcu_wdata), .mcu_rdata(mcu_rdata),
    .limit_select_pin(limit_select_pin), .pin_function_config(pin_function_config),
    .battery_bad(battery_bad), .input_limit_ma(input_limit_ma),
    .input_limit_invalid(input_limit_invalid), .charge_current_ma(charge_current_ma),
    .max_voltage_mv(max_voltage_mv), .max_voltage_invalid(max_voltage_invalid),
    .bad_batt_stop(bad_batt_stop));

  host_model host_model_inst (
    .ref_clk(ref_clk), .rst(rst), .go(h_go), .wr(h_wr), .dly(h_dly),
    .addr(h_addr), .wdata(d), .busy(h_busy),
    .mcu_wr(mcu_wr), .mcu_rd(mcu_rd), .mcu_addr(mcu_addr), .mcu_wdata(mcu_wdata));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic test_done();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done

  task automatic cmp_rd(input logic [7:0] got);
    logic [7:0] exp;
    exp = (q.size() > 0) ? q.pop_front() : 8'hXX;
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: read %h expected %h", $time, got, exp);
    end
  endtask : cmp_rd

  task automatic cmp_out();
    @(negedge ref_clk);
    n_tests++;
    if ({input_limit_ma, input_limit_invalid, charge_current_ma, max_voltage_mv,
         max_voltage_invalid, bad_batt_stop} !== {e_lim, e_linv, e_cur, e_mv, e_vinv, e_stop}) begin
      n_mismatch++;
      $display("Error at %0t: settings %h %b %h %h %b %b", $time, input_limit_ma,
               input_limit_invalid, charge_current_ma, max_voltage_mv,
               max_voltage_invalid, bad_batt_stop);
    end
    @(posedge ref_clk);
  endtask : cmp_out

  // Serial accesses use the upper address byte as page; d feeds host data
  task automatic acc(input logic m, input logic w, input logic [15:0] a,
                     input logic [7:0] v);
    if (m) begin
      h_wr <= w;
      h_addr <= a;
      d <= v;
      h_dly <= 4'($urandom_range(0, 3));
      h_go <= 1'b1;
      @(posedge ref_clk);
      h_go <= 1'b0;
      @(posedge ref_clk);
      while (h_busy) @(posedge ref_clk);
    end else begin
      ser_page <= a[15:8];
      ser_addr <= a[7:0];
      ser_wdata <= v;
      ser_wr <= w;
      ser_rd <= ~w;
      @(posedge ref_clk);
      ser_wr <= 1'b0;
      ser_rd <= 1'b0;
      ser_wdata <= ~v;
      @(posedge ref_clk);
    end
  endtask : acc

  task automatic rd(input logic m, input logic [15:0] a, input logic [7:0] e);
    q.push_back(e);
    acc(m, 1'b0, a, 8'h00);
  endtask : rd

  task automatic do_reset();
    rst <= 1'b1;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    {e_lim, e_linv, e_cur, e_mv, e_vinv, e_stop} = {MA_100, 1'b0, MA_100, MV_4100, 2'b00};
  endtask : do_reset

  ////////////////////////////////////////////////////////////////////////////
  // Read data lands one edge after the strobe is taken
  always @(posedge ref_clk) begin
    pend_s <= ser_rd & ce;
    pend_m <= mcu_rd & ce;
  end

  always @(negedge ref_clk) begin
    if (pend_s === 1'b1 || pend_m === 1'b1) begin
      cmp_rd(pend_s ? ser_rdata : mcu_rdata);
    end
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    test_done();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst, ce, ser_wr, ser_rd, h_go, h_wr} = 6'h30;
    {ser_page, ser_addr, ser_wdata, d, h_addr, h_dly} = 52'h0;
    {limit_select_pin, pin_function_config, battery_bad} = 3'h0;
    n_mismatch = 0;
    n_tests = 0;
    void'($urandom(32'hAF14));
    do_reset();
    rd(1'b0, 16'h0090, 8'h80);
    rd(1'b1, 16'hA091, 8'h00);
    cmp_out();
    for (int i = 0; i < 8; i++) begin
      acc(1'b1, 1'b1, 16'hA090, 8'h80 | 8'(i));
      if (i < 5) begin
        e_lim = (i == 0) ? MA_100 : 12'(500 * i);
      end
      e_linv = (i > 4);
      cmp_out();
    end
    for (int i = 0; i < 16; i++) begin
      acc(1'b0, 1'b1, 16'h0091, {2'b00, i[1:0], i[3:0]});
      e_cur = (i < 2) ? 12'h064 : 12'(100 * i);
      if (i[1:0] != 2'b11) begin
        e_mv = 13'(4100 + 50 * i[1:0]);
      end
      e_vinv = (i[1:0] == 2'b11);
      cmp_out();
    end
    // External source with the pin function off stays invalid
    acc(1'b1, 1'b1, 16'hA090, 8'h07);
    e_linv = 1'b1;
    cmp_out();
    pin_function_config <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      n = $urandom_range(0, 1);
      limit_select_pin <= n[0];
      repeat (3) @(posedge ref_clk);
      e_lim = n[0] ? MA_1500 : MA_500;
      e_linv = 1'b0;
      cmp_out();
    end
    for (int i = 0; i < 4; i++) begin
      acc(1'b0, 1'b1, 16'h0090, 8'($urandom));
      rd(1'b1, 16'hA090, ser_wdata ^ 8'hFF);
      acc(1'b1, 1'b1, 16'hA091, 8'($urandom));
      rd(1'b0, 16'h0091, d);
    end
    // Last charging value must survive unmapped and frozen writes
    chg_keep = d;
    acc(1'b0, 1'b1, 16'h0191, 8'h5A);
    acc(1'b1, 1'b1, 16'hA092, 8'h5A);
    rd(1'b0, 16'h0190, 8'h00);
    rd(1'b1, 16'hA092, 8'h00);
    ce <= 1'b0;
    acc(1'b0, 1'b1, 16'h0091, 8'h3C);
    ce <= 1'b1;
    rd(1'b0, 16'h0091, chg_keep);
    // Mid-run reset brings back the defaults
    do_reset();
    rd(1'b1, 16'hA090, 8'h80);
    rd(1'b0, 16'h0091, 8'h00);
    battery_bad <= 1'b1;
    repeat (18) @(posedge ref_clk);
    cmp_out();
    n = 0;
    while (bad_batt_stop !== 1'b1 && n < 10) begin
      @(posedge ref_clk);
      n++;
    end
    e_stop = 1'b1;
    cmp_out();
    battery_bad <= 1'b0;
    repeat (4) @(posedge ref_clk);
    e_stop = 1'b0;
    cmp_out();
    repeat (4) @(posedge ref_clk);
    test_done();
  end
endmodule : charger_limit_config_regs_tb
`default_nettype wire

// *** tb/host_model.sv ***
// Controller-side host model driving the register port of the block
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Requests from the bench
  input  wire logic        go,
  input  wire logic        wr,
  input  wire logic [3:0]  dly,
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  wdata,
  output logic             busy,
  // Controller register port
  output logic             mcu_wr,
  output logic             mcu_rd,
  output logic [15:0]      mcu_addr,
  output logic [7:0]       mcu_wdata
);
  logic [3:0] wait_cnt;
  logic       wr_q;

  always @(posedge ref_clk) begin
    if (rst) begin
      busy <= 1'b0;
      mcu_wr <= 1'b0;
      mcu_rd <= 1'b0;
      mcu_addr <= 16'h0000;
      mcu_wdata <= 8'h00;
      wait_cnt <= 4'h0;
      wr_q <= 1'b0;
    end else if (mcu_wr || mcu_rd) begin
      // Released lines show garbage, never the last value
      mcu_wr <= 1'b0;
      mcu_rd <= 1'b0;
      mcu_addr <= ~mcu_addr;
      mcu_wdata <= ~mcu_wdata;
      busy <= 1'b0;
    end else if (busy && wait_cnt != 4'h0) begin
      wait_cnt <= wait_cnt - 4'h1;
    end else if (busy) begin
      // One 8-bit access per one-cycle strobe
      mcu_wr <= wr_q;
      mcu_rd <= ~wr_q;
    end else if (go) begin
      busy <= 1'b1;
      wait_cnt <= dly;
      wr_q <= wr;
      mcu_addr <= addr;
      mcu_wdata <= wdata;
    end
  end
endmodule : host_model
`default_nettype wire
